// ===== core/qdse_pkg.sv
/*
 * Constants, symbol and code encodings for the quadrature duobinary
 * transmit symbol encoder.
 * Assumes one 40 MHz clock and a MAC that presents one symbol per pulse.
 */
// Notes on behaviour
// - Successive codes alternate in-phase then quadrature, odd codes in-phase.
// - Remodulator silence is 2,0,2,0,4,0,0,0, restarting each silence period.
// - Remodulator pseudo-silence may stop after any even code count.
// - Station: first two and last two silence symbols become code 2.
// - Station: other silence is code 0; transmitter off while only those.
// - Fill is 4,0,0,0, restarting at 4, and that 4 goes in-phase.
// - Scrambler presets to all ones at each delimiter symbol.
// - Delimiter symbols are code 2; first delimiter code goes in-phase.
// - After an eight-symbol delimiter, the next code starts a new octet.
// - First delimiter symbol is taken as a delimiter start.
// - Data symbols pass the scrambler; the scrambled bit is encoded.
// - Scrambled zero is code 0, scrambled one is code 4.
// - Management may fall back to the single-symbol-per-baud method; here fallback only holds the transmitter off.
// - Station infers network signaling type from received pseudo-silence.
// - Inference redone after 2 ms without modulation or loopback release.
// - Type mismatch is reported and inhibits transmission until agreement.
// - Repeated uniform octet pair: invert last in-phase, last two quadrature 2.
// - Scrambler divides by taps at delays six and seven, period 127.
package qdse_pkg;

	typedef enum logic [2:0]
	{
		QDSE_SILENCE = 3'h0,
		QDSE_PAD     = 3'h1,
		QDSE_NONDATA = 3'h2,
		QDSE_ZERO    = 3'h3,
		QDSE_ONE     = 3'h4
	} qdse_sym_t;

	typedef enum logic [1:0]
	{
		QDSE_C0 = 2'h0,
		QDSE_C2 = 2'h1,
		QDSE_C4 = 2'h2
	} qdse_code_t;

	localparam int          LINE_LEN      = 8;
	localparam logic [6:0]  SCR_PRESET    = 7'h7F;
	localparam int          CLK_MHZ       = 40;
	localparam int          QUIET_TIME_US = 2000;
	localparam int          QUIET_W       = 17;
	localparam logic [16:0] QUIET_CYCLES  = 17'(QUIET_TIME_US * CLK_MHZ);
	localparam logic [2:0]  DELIM_LAST    = 3'h7;
	localparam logic [2:0]  OCTET_LAST    = 3'h7;
	localparam logic [1:0]  PSIL_LAST     = 2'h3;

endpackage

// ===== core/qdse_scrambler.sv
/*
 * Self-synchronising data scrambler, seven stages.
 * Assumes step and preset are single-cycle strobes from the encoder.
 */
`timescale 1ns/1ps
module qdse_scrambler
(
	input  wire logic ref_clk,
	input  wire logic reset,
	input  wire logic preset,
	input  wire logic step,
	input  wire logic data_in,
	output wire logic data_out
);
	logic [6:0] state;
	wire        feedback;

	assign feedback = data_in ^ state[5] ^ state[6];
	assign data_out = feedback;

	always_ff @(posedge ref_clk)
	begin
		if (reset || preset)
			state <= qdse_pkg::SCR_PRESET;
		else if (step)
			state <= {state[5:0], feedback};
	end

	chk_scr_preset: assert property (@(posedge ref_clk)
		preset |=> state == qdse_pkg::SCR_PRESET)
		else $error("scrambler not preset to all ones");
	chk_scr_taps: assert property (@(posedge ref_clk) disable iff (reset)
		step && !preset |=> state[0] == ($past(data_in)
		^ $past(state[5]) ^ $past(state[6])))
		else $error("scrambler feedback wrong");

endmodule // qdse_scrambler

// ===== core/qdse_type_infer.sv
/*
 * Network signaling type inference from received forward-channel bauds.
 * Assumes the receive path delivers one baud per pulse and a separate
 * pulse when the single-symbol pseudo-silence is recognised.
 */
`timescale 1ns/1ps
module qdse_type_infer
#(
	parameter logic [16:0] QUIET_CYCLES = qdse_pkg::QUIET_CYCLES
)
(
	input  wire logic       ref_clk,
	input  wire logic       reset,
	input  wire logic       rx_baud_valid,
	input  wire logic [1:0] rx_i_code,
	input  wire logic [1:0] rx_q_code,
	input  wire logic       rx_basic_psil,
	input  wire logic       rx_modulation,
	input  wire logic       loopback_sel,
	input  wire logic       ext_mode,
	output wire logic       type_valid,
	output wire logic       type_ext,
	output wire logic       type_report,
	output wire logic       type_mismatch
);
	logic [1:0]  match;
	logic [16:0] quiet;
	logic        loop_d;
	logic        valid;
	logic        ext;
	logic        report;
	logic [1:0]  want_i;
	wire         step_ok;
	wire         first_ok;
	wire         ext_seen;
	wire         restart;
	wire         learn;

	// The extended pseudo-silence reads 2,2,4,0 in-phase with quadrature 0.
	always_comb
	begin
		want_i = qdse_pkg::QDSE_C0;
		case (match)
			2'h0: want_i = qdse_pkg::QDSE_C2;
			2'h1: want_i = qdse_pkg::QDSE_C2;
			2'h2: want_i = qdse_pkg::QDSE_C4;
			default: want_i = qdse_pkg::QDSE_C0;
		endcase
	end
	assign step_ok  = rx_i_code == want_i && rx_q_code == qdse_pkg::QDSE_C0;
	assign first_ok = rx_i_code == qdse_pkg::QDSE_C2
		&& rx_q_code == qdse_pkg::QDSE_C0;
	assign ext_seen = rx_baud_valid && step_ok
		&& match == qdse_pkg::PSIL_LAST;
	assign restart  = quiet == QUIET_CYCLES || (loop_d && !loopback_sel);
	assign learn    = !valid && (ext_seen || rx_basic_psil);

	always_ff @(posedge ref_clk)
	begin
		if (reset)
		begin
			match  <= 2'h0;
			quiet  <= 17'h00000;
			loop_d <= 1'b0;
			valid  <= 1'b0;
			ext    <= 1'b0;
			report <= 1'b0;
		end
		else
		begin
			loop_d <= loopback_sel;
			if (rx_baud_valid)
				match <= step_ok ? match + 2'h1 : {1'b0, first_ok};
			if (rx_modulation || restart)
				quiet <= 17'h00000;
			else
				quiet <= quiet + 17'h00001;
			report <= learn && (ext_seen != ext_mode);
			if (restart)
				valid <= 1'b0;
			else if (learn)
			begin
				valid <= 1'b1;
				ext   <= ext_seen;
			end
		end
	end

	assign type_valid    = valid;
	assign type_ext      = ext;
	assign type_report   = report;
	assign type_mismatch = valid && (ext != ext_mode);

	chk_quiet_redo: assert property (@(posedge ref_clk) disable iff (reset)
		quiet == QUIET_CYCLES |=> !valid)
		else $error("inference not redone after quiet period");
	chk_ext_learn: assert property (@(posedge ref_clk) disable iff (reset)
		!valid && ext_seen && !restart |=> valid && ext)
		else $error("extended pseudo-silence not inferred");

endmodule // qdse_type_infer

// ===== core/qdse_encoder.sv
/*
 * Quadrature duobinary transmit symbol encoder, top level.
 * Assumes the MAC presents one symbol per sym_valid pulse, fill octets
 * of even length before each delimiter, and mode inputs held steady.
 * Codes pass an eight-deep line so that the last two silence codes and
 * the octet repair can be rewritten before they leave.
 */
`timescale 1ns/1ps
module qdse_encoder
#(
	parameter logic [16:0] QUIET_CYCLES = qdse_pkg::QUIET_CYCLES
)
(
	input  wire logic       ref_clk,
	input  wire logic       reset,
	input  wire logic       sym_valid,
	input  wire logic [2:0] sym,
	input  wire logic       remod_mode,
	input  wire logic       mgmt_ext_select,
	input  wire logic       mgmt_tx_disable,
	input  wire logic       rx_baud_valid,
	input  wire logic [1:0] rx_i_code,
	input  wire logic [1:0] rx_q_code,
	input  wire logic       rx_basic_psil,
	input  wire logic       rx_modulation,
	input  wire logic       loopback_sel,
	output logic            baud_valid,
	output logic [1:0]      i_code,
	output logic [1:0]      q_code,
	output logic            tx_enable,
	output wire logic       fallback_active,
	output wire logic       net_type_valid,
	output wire logic       net_type_ext,
	output wire logic       net_type_report
);
	typedef enum logic [3:0]
	{
		QDSE_ST_SIL   = 4'h1,
		QDSE_ST_FILL  = 4'h2,
		QDSE_ST_DELIM = 4'h4,
		QDSE_ST_DATA  = 4'h8
	} qdse_state_t;

	qdse_state_t state;
	qdse_state_t next_state;
	logic [1:0]  lc [qdse_pkg::LINE_LEN];
	logic [7:0]  ls;
	logic [7:0]  lf;
	logic [7:0]  lv;
	logic [1:0]  sh_c [qdse_pkg::LINE_LEN];
	logic [1:0]  nx_c [qdse_pkg::LINE_LEN];
	logic [7:0]  sh_s;
	logic [7:0]  sh_f;
	logic [7:0]  sh_v;
	logic [7:0]  nx_s;
	logic [2:0]  psil_pos;
	logic [1:0]  fill_pos;
	logic [1:0]  sil_cnt;
	logic [2:0]  delim_cnt;
	logic [2:0]  oct_pos;
	logic        oct_on;
	logic        prev_ok;
	logic [1:0]  prev_a;
	logic [1:0]  prev_b;
	logic        ph;
	logic [1:0]  hold_c;
	logic        hold_s;
	logic        ext_mode;
	logic [1:0]  new_code;
	logic [1:0]  psil_code;
	wire         is_sil;
	wire         is_pad;
	wire         is_nd;
	wire         is_data;
	wire         sil_start;
	wire         fill_start;
	wire         delim_start;
	wire         delim_end;
	wire         scr_bit;
	wire         new_force;
	wire         new_sil;
	wire         lead_edit;
	wire         oct_done;
	wire         uniform;
	wire         repair;
	wire         out_i;
	wire         mismatch;
	wire         inhibit;

	assign is_sil      = sym == qdse_pkg::QDSE_SILENCE;
	assign is_pad      = sym == qdse_pkg::QDSE_PAD;
	assign is_nd       = sym == qdse_pkg::QDSE_NONDATA;
	assign is_data     = sym == qdse_pkg::QDSE_ZERO || sym == qdse_pkg::QDSE_ONE;
	assign sil_start   = is_sil && state != QDSE_ST_SIL;
	assign fill_start  = is_pad && state != QDSE_ST_FILL;
	assign delim_start = is_nd && state != QDSE_ST_DELIM;
	assign delim_end   = state == QDSE_ST_DELIM && delim_cnt == qdse_pkg::DELIM_LAST;

	qdse_scrambler u_scrambler
	(
		.ref_clk  (ref_clk),
		.reset    (reset),
		.preset   (sym_valid && is_nd),
		.step     (sym_valid && is_data),
		.data_in  (sym == qdse_pkg::QDSE_ONE),
		.data_out (scr_bit)
	);

	always_comb
	begin
		psil_code = qdse_pkg::QDSE_C0;
		case (psil_pos)
			3'h0: psil_code = qdse_pkg::QDSE_C2;
			3'h2: psil_code = qdse_pkg::QDSE_C2;
			3'h4: psil_code = qdse_pkg::QDSE_C4;
			default: psil_code = qdse_pkg::QDSE_C0;
		endcase
	end

	always_comb
	begin
		new_code = qdse_pkg::QDSE_C2;
		next_state = state;
		case (sym)
			qdse_pkg::QDSE_SILENCE:
			begin
				next_state = QDSE_ST_SIL;
				if (remod_mode)
					new_code = sil_start ? qdse_pkg::QDSE_C2 : psil_code;
				else if (sil_start || sil_cnt < 2'h2)
					new_code = qdse_pkg::QDSE_C2;
				else
					new_code = qdse_pkg::QDSE_C0;
			end
			qdse_pkg::QDSE_PAD:
			begin
				next_state = QDSE_ST_FILL;
				new_code = (fill_start || fill_pos == 2'h0) ?
					qdse_pkg::QDSE_C4 : qdse_pkg::QDSE_C0;
			end
			qdse_pkg::QDSE_NONDATA:
				next_state = delim_end ? QDSE_ST_DATA : QDSE_ST_DELIM;
			qdse_pkg::QDSE_ZERO, qdse_pkg::QDSE_ONE:
			begin
				next_state = (delim_end || state != QDSE_ST_DELIM) ?
					QDSE_ST_DATA : QDSE_ST_DELIM;
				new_code = scr_bit ? qdse_pkg::QDSE_C4 : qdse_pkg::QDSE_C0;
			end
			default:
				next_state = state;
		endcase
	end

	assign new_force = fill_start || delim_start;
	assign new_sil   = !remod_mode && is_sil && new_code == qdse_pkg::QDSE_C0;
	// Rewriting two queued zeros is what gives the last two silences code 2.
	assign lead_edit = !remod_mode && !is_sil && state == QDSE_ST_SIL;
	assign oct_done  = oct_on && oct_pos == qdse_pkg::OCTET_LAST && is_data;

	always_comb
	begin
		sh_c[0] = new_code;
		sh_s[0] = new_sil;
		sh_f[0] = new_force;
		sh_v[0] = 1'b1;
		for (int k = 1; k < qdse_pkg::LINE_LEN; k++)
		begin
			sh_c[k] = lc[k - 1];
			sh_s[k] = ls[k - 1];
			sh_f[k] = lf[k - 1];
			sh_v[k] = lv[k - 1];
		end
	end

	assign uniform = oct_done
		&& (sh_c[7] == qdse_pkg::QDSE_C0 || sh_c[7] == qdse_pkg::QDSE_C4)
		&& (sh_c[6] == qdse_pkg::QDSE_C0 || sh_c[6] == qdse_pkg::QDSE_C4)
		&& sh_c[5] == sh_c[7] && sh_c[3] == sh_c[7] && sh_c[1] == sh_c[7]
		&& sh_c[4] == sh_c[6] && sh_c[2] == sh_c[6] && sh_c[0] == sh_c[6];
	assign repair = uniform && prev_ok
		&& prev_a == sh_c[7] && prev_b == sh_c[6];

	genvar g;
	generate
		for (g = 0; g < qdse_pkg::LINE_LEN; g++)
		begin : g_line
			wire lead = lead_edit && (g == 1 || g == 2) && sh_s[g];
			wire fix2 = repair && (g == 0 || g == 2);
			wire inv  = repair && g == 1;
			assign nx_s[g] = sh_s[g] && !lead;
			assign nx_c[g] = (lead || fix2) ? qdse_pkg::QDSE_C2 :
				inv ? (sh_c[g] == qdse_pkg::QDSE_C0 ?
				qdse_pkg::QDSE_C4 : qdse_pkg::QDSE_C0) : sh_c[g];
			always_ff @(posedge ref_clk)
			begin
				if (reset)
					lc[g] <= qdse_pkg::QDSE_C0;
				else if (sym_valid)
					lc[g] <= nx_c[g];
			end
		end
	endgenerate

	assign out_i    = lf[7] || !ph;
	assign mismatch = net_type_valid && (net_type_ext != ext_mode);
	assign inhibit  = mgmt_tx_disable || mismatch || !ext_mode;

	always_ff @(posedge ref_clk)
	begin
		if (reset)
		begin
			state <= QDSE_ST_SIL;
			ls <= 8'h00;
			lf <= 8'h00;
			lv <= 8'h00;
			psil_pos <= 3'h0;
			fill_pos <= 2'h0;
			sil_cnt <= 2'h0;
			delim_cnt <= 3'h0;
			oct_on <= 1'b0;
			oct_pos <= 3'h0;
			prev_ok <= 1'b0;
			prev_a <= qdse_pkg::QDSE_C0;
			prev_b <= qdse_pkg::QDSE_C0;
			ph <= 1'b0;
			hold_c <= qdse_pkg::QDSE_C0;
			hold_s <= 1'b0;
			ext_mode <= 1'b0;
			baud_valid <= 1'b0;
			i_code <= qdse_pkg::QDSE_C0;
			q_code <= qdse_pkg::QDSE_C0;
			tx_enable <= 1'b0;
		end
		else
		begin
			ext_mode <= mgmt_ext_select;
			baud_valid <= 1'b0;
			if (sym_valid)
			begin
				state <= next_state;
				ls <= nx_s;
				lf <= sh_f;
				lv <= sh_v;
				// Restarting here lets a period end after any even count.
				psil_pos <= sil_start ? 3'h1 : psil_pos + 3'h1;
				fill_pos <= fill_start ? 2'h1 : fill_pos + 2'h1;
				sil_cnt <= !is_sil ? 2'h0 :
					(sil_start ? 2'h1 : (sil_cnt == 2'h3 ? 2'h3 : sil_cnt + 2'h1));
				delim_cnt <= delim_start ? 3'h1 : delim_cnt + 3'h1;
				if (delim_end)
				begin
					oct_on <= 1'b1;
					oct_pos <= 3'h0;
				end
				else if (is_sil || is_pad)
					oct_on <= 1'b0;
				else
					oct_pos <= oct_pos + 3'h1;
				if (oct_done)
				begin
					prev_ok <= uniform && !repair;
					prev_a <= sh_c[7];
					prev_b <= sh_c[6];
				end
				if (lv[7] && out_i)
				begin
					hold_c <= lc[7];
					hold_s <= ls[7];
					ph <= 1'b1;
				end
				else if (lv[7])
				begin
					baud_valid <= 1'b1;
					i_code <= hold_c;
					q_code <= lc[7];
					tx_enable <= !inhibit && !(hold_s && ls[7]);
					ph <= 1'b0;
				end
			end
		end
	end

	assign fallback_active = !ext_mode;

	qdse_type_infer #(.QUIET_CYCLES(QUIET_CYCLES)) u_type_infer
	(
		.ref_clk       (ref_clk),
		.reset         (reset),
		.rx_baud_valid (rx_baud_valid),
		.rx_i_code     (rx_i_code),
		.rx_q_code     (rx_q_code),
		.rx_basic_psil (rx_basic_psil && !remod_mode),
		.rx_modulation (rx_modulation),
		.loopback_sel  (loopback_sel),
		.ext_mode      (ext_mode),
		.type_valid    (net_type_valid),
		.type_ext      (net_type_ext),
		.type_report   (net_type_report),
		.type_mismatch ()
	);

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (reset);

	chk_psil_start: assert property (remod_mode && sym_valid && sil_start
		|=> lc[0] == qdse_pkg::QDSE_C2)
		else $error("pseudo-silence did not restart at code 2");
	chk_sil_lead: assert property (!remod_mode && sym_valid && sil_start
		##1 sym_valid && is_sil |=> lc[0] == qdse_pkg::QDSE_C2
		&& lc[1] == qdse_pkg::QDSE_C2)
		else $error("first two silences not code 2");
	chk_fill_start: assert property (sym_valid && fill_start
		|=> lc[0] == qdse_pkg::QDSE_C4 && lf[0])
		else $error("fill did not restart at in-phase code 4");
	chk_delim_code: assert property (sym_valid && is_nd
		|=> lc[0] == qdse_pkg::QDSE_C2)
		else $error("delimiter symbol not code 2");
	chk_data_map: assert property (sym_valid && is_data && !oct_done
		|=> lc[0] == ($past(scr_bit) ? qdse_pkg::QDSE_C4 : qdse_pkg::QDSE_C0))
		else $error("scrambled data mapped wrongly");
	chk_octet_start: assert property (sym_valid && delim_end
		|=> oct_on && oct_pos == 3'h0)
		else $error("octet alignment not started after delimiter");
	chk_repair_fix: assert property (sym_valid && repair
		|=> lc[0] == qdse_pkg::QDSE_C2 && lc[2] == qdse_pkg::QDSE_C2
		&& lc[1] != $past(sh_c[1]))
		else $error("repeated octet not altered");
	chk_inhibit_tx: assert property (sym_valid && lv[7] && !out_i && inhibit
		|=> baud_valid && !tx_enable)
		else $error("transmit enabled while inhibited");
	chk_iq_pair: assert property (baud_valid |-> !ph
		&& $past(ph) == 1'b1)
		else $error("baud issued without in-phase half");
	chk_reset_state: assert property (@(posedge ref_clk) disable iff (1'b0)
		reset |=> !ext_mode && !oct_on && fallback_active)
		else $error("reset state wrong");

	cov_baud: cover property (baud_valid && tx_enable);
	cov_repair: cover property (sym_valid && repair);
	cov_delim: cover property (sym_valid && delim_end);
	cov_mismatch: cover property (mismatch);

endmodule // qdse_encoder

// ===== tb/qdse_mac_model.sv
/*
 * MAC symbol source model for the encoder bench.
 * Assumes the bench queues symbols with push_run and polls pending.
 */
`timescale 1ns/1ps
module qdse_mac_model
(
	input  wire logic ref_clk,
	input  wire logic reset,
	input  wire logic slow,
	output logic      sym_valid,
	output logic [2:0] sym
);
	logic [2:0] q[$];
	logic [2:0] last_push;
	logic       gap;

	initial
	begin
		sym_valid = 1'b0;
		sym = 3'h0;
		gap = 1'b0;
		last_push = 3'h1;
	end

	// A short fill run straight after silence is stretched to the minimum.
	function void push_run(input logic [2:0] s, input int n);
		int k;
		k = n;
		if (s == 3'h1 && last_push == 3'h0 && k < 64)
			k = 64;
		for (int j = 0; j < k; j++)
			q.push_back(s);
		last_push = s;
	endfunction

	function int pending();
		return q.size();
	endfunction

	// Idle symbol lines toggle so that a stale value is never mistaken.
	always @(posedge ref_clk)
	begin
		gap <= slow & ~gap;
		if (!reset && q.size() != 0 && !gap)
		begin
			sym_valid <= 1'b1;
			sym <= q.pop_front();
		end
		else
		begin
			sym_valid <= 1'b0;
			sym <= ~sym;
		end
	end
endmodule // qdse_mac_model

// ===== tb/qdse_encoder_tb_top.sv
/*
 * Self-checking bench for the quadrature symbol encoder.
 * Assumes the core files and the MAC model are compiled first.
 */
`timescale 1ns/1ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin n_errors++; \
$display("mismatch t=%0t got=%h exp=%h", $time, g, e); end end
module qdse_encoder_tb_top;
	localparam logic [16:0] QT = 17'h00032;
	localparam logic [1:0] C0 = qdse_pkg::QDSE_C0;
	localparam logic [1:0] C2 = qdse_pkg::QDSE_C2;
	localparam logic [1:0] C4 = qdse_pkg::QDSE_C4;
	localparam logic [2:0] S_SIL = qdse_pkg::QDSE_SILENCE;
	localparam logic [2:0] S_PAD = qdse_pkg::QDSE_PAD;
	localparam logic [2:0] S_ND = qdse_pkg::QDSE_NONDATA;
	localparam logic [2:0] S_ZERO = qdse_pkg::QDSE_ZERO;
	localparam logic [2:0] S_ONE = qdse_pkg::QDSE_ONE;
	logic ref_clk, reset, slow, remod_mode, mgmt_ext_select;
	logic mgmt_tx_disable, rx_baud_valid, rx_basic_psil;
	logic rx_modulation, loopback_sel, sym_valid, baud_valid;
	logic tx_enable, fallback_active, net_type_valid;
	logic net_type_ext, net_type_report;
	logic [1:0] rx_i_code, rx_q_code, i_code, q_code;
	logic [2:0] sym;
	logic [1:0] gi[$], gq[$], ei[$], eq[$];
	logic ge[$], ee[$];
	logic [6:0] scr;
	int n_errors, n_checks, n_rep;

	always #12.5 ref_clk = ~ref_clk;

	qdse_mac_model mac (.ref_clk(ref_clk), .reset(reset), .slow(slow),
		.sym_valid(sym_valid), .sym(sym));

	qdse_encoder #(.QUIET_CYCLES(QT)) dut (.ref_clk(ref_clk),
		.reset(reset), .sym_valid(sym_valid), .sym(sym),
		.remod_mode(remod_mode), .mgmt_ext_select(mgmt_ext_select),
		.mgmt_tx_disable(mgmt_tx_disable), .rx_baud_valid(rx_baud_valid),
		.rx_i_code(rx_i_code), .rx_q_code(rx_q_code),
		.rx_basic_psil(rx_basic_psil), .rx_modulation(rx_modulation),
		.loopback_sel(loopback_sel), .baud_valid(baud_valid),
		.i_code(i_code), .q_code(q_code), .tx_enable(tx_enable),
		.fallback_active(fallback_active),
		.net_type_valid(net_type_valid), .net_type_ext(net_type_ext),
		.net_type_report(net_type_report));

	always @(posedge ref_clk)
	begin
		if (net_type_report === 1'b1)
			n_rep++;
		if (baud_valid === 1'b1)
		begin
			gi.push_back(i_code);
			gq.push_back(q_code);
			ge.push_back(tx_enable);
		end
	end

	task tick(input int n);
		repeat (n) @(posedge ref_clk);
	endtask

	task complete_run;
		$display("checks %0d errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	task clr;
		gi.delete();
		gq.delete();
		ge.delete();
		ei.delete();
		eq.delete();
		ee.delete();
	endtask

	task ep(input logic [1:0] a, input logic [1:0] b, input logic en);
		ei.push_back(a);
		eq.push_back(b);
		ee.push_back(en);
	endtask

	// The bench keeps its own scrambler so expectations never reuse the core.
	function logic [1:0] dcode(input logic d);
		logic o;
		o = d ^ scr[5] ^ scr[6];
		scr = {scr[5:0], o};
		return o ? C4 : C0;
	endfunction

	task drain;
		int k;
		k = 0;
		while (mac.pending() != 0 && k < 2000)
		begin
			tick(1);
			k++;
		end
		if (k >= 2000)
		begin
			n_errors++;
			complete_run();
		end
		tick(4);
	endtask

	task cmp(input logic en);
		`CHK(gi.size() >= ei.size(), 1'b1)
		for (int j = 0; j < ei.size(); j++)
		begin
			`CHK(gi[j], ei[j])
			`CHK(gq[j], eq[j])
			if (en)
				`CHK(ge[j], ee[j])
		end
	endtask

	task en_off;
		for (int j = 0; j < 4; j++)
			`CHK(ge[j], 1'b0)
	endtask

	task do_reset(input logic remod);
		tick(1);
		reset <= 1'b1;
		remod_mode <= remod;
		mgmt_ext_select <= 1'b0;
		tick(10);
		#1;
		`CHK(baud_valid, 1'b0)
		`CHK(tx_enable, 1'b0)
		`CHK(fallback_active, 1'b1)
		`CHK(net_type_valid, 1'b0)
		tick(1);
		reset <= 1'b0;
		mgmt_ext_select <= 1'b1;
		scr = 7'h7F;
		clr();
	endtask

	task rx_ext;
		logic [1:0] pat[4];
		pat = '{C2, C2, C4, C0};
		for (int j = 0; j < 4; j++)
		begin
			tick(1);
			rx_baud_valid <= 1'b1;
			rx_i_code <= pat[j];
			rx_q_code <= C0;
			tick(1);
			rx_baud_valid <= 1'b0;
			rx_i_code <= ~pat[j];
			rx_q_code <= 2'h3;
		end
	endtask

	task sc_remod;
		do_reset(1'b1);
		mac.push_run(S_SIL, 6);
		mac.push_run(S_PAD, 16);
		mac.push_run(S_SIL, 4);
		mac.push_run(S_PAD, 16);
		drain();
		ep(C2, C0, 1'b0);
		ep(C2, C0, 1'b0);
		ep(C4, C0, 1'b0);
		for (int j = 0; j < 32; j++)
			ep(j % 2 ? C0 : C4, C0, 1'b0);
		ep(C2, C0, 1'b0);
		ep(C2, C0, 1'b0);
		cmp(1'b0);
	endtask

	task sc_delim;
		logic [2:0] dl[8];
		logic [1:0] cd[8];
		logic r;
		do_reset(1'b1);
		dl = '{S_ND, S_ND, S_ZERO, S_ND, S_ND, S_ONE, S_ONE, S_ZERO};
		mac.push_run(S_PAD, 8);
		for (int j = 0; j < 4; j++)
			ep(j % 2 ? C0 : C4, C0, 1'b0);
		for (int j = 0; j < 8; j++)
		begin
			mac.push_run(dl[j], 1);
			if (dl[j] == S_ND)
				scr = 7'h7F;
			cd[j] = (dl[j] == S_ND) ? C2 : dcode(dl[j] == S_ONE);
		end
		for (int j = 0; j < 8; j += 2)
			ep(cd[j], cd[j + 1], 1'b0);
		for (int j = 0; j < 24; j++)
		begin
			r = scr[5] ^ scr[6];
			void'(dcode(r));
			mac.push_run(r ? S_ONE : S_ZERO, 1);
		end
		for (int j = 0; j < 12; j++)
			ep(j == 7 ? C4 : C0, (j == 6 || j == 7) ? C2 : C0, 1'b0);
		mac.push_run(S_ONE, 1);
		mac.push_run(S_PAD, 16);
		ep(C4, C0, 1'b0);
		ep(C0, C0, 1'b0);
		drain();
		cmp(1'b0);
	endtask

	task sc_station;
		do_reset(1'b0);
		slow <= 1'b1;
		rx_ext();
		tick(3);
		#1;
		`CHK(net_type_valid, 1'b1)
		`CHK(net_type_ext, 1'b1)
		`CHK(n_rep, 0)
		mac.push_run(S_PAD, 8);
		mac.push_run(S_SIL, 8);
		mac.push_run(S_PAD, 8);
		drain();
		for (int j = 0; j < 4; j++)
			ep(j % 2 ? C0 : C4, C0, 1'b1);
		ep(C2, C2, 1'b1);
		ep(C0, C0, 1'b0);
		ep(C0, C0, 1'b0);
		ep(C2, C2, 1'b1);
		ep(C4, C0, 1'b1);
		cmp(1'b1);
		// Management disable alone must hold the transmitter off.
		tick(1);
		mgmt_tx_disable <= 1'b1;
		clr();
		mac.push_run(S_PAD, 16);
		drain();
		en_off();
		tick(1);
		mgmt_tx_disable <= 1'b0;
	endtask

	task sc_type;
		tick(1);
		slow <= 1'b0;
		loopback_sel <= 1'b1;
		tick(2);
		loopback_sel <= 1'b0;
		tick(3);
		#1;
		`CHK(net_type_valid, 1'b0)
		tick(1);
		rx_basic_psil <= 1'b1;
		tick(1);
		rx_basic_psil <= 1'b0;
		tick(3);
		#1;
		`CHK(net_type_valid, 1'b1)
		`CHK(net_type_ext, 1'b0)
		`CHK(n_rep, 1)
		clr();
		mac.push_run(S_PAD, 16);
		drain();
		en_off();
		tick(1);
		rx_modulation <= 1'b0;
		tick(int'(QT) - 3);
		#1;
		`CHK(net_type_valid, 1'b1)
		tick(6);
		#1;
		`CHK(net_type_valid, 1'b0)
		tick(1);
		rx_modulation <= 1'b1;
		rx_ext();
		tick(3);
		#1;
		`CHK(net_type_ext, 1'b1)
		`CHK(n_rep, 1)
		`CHK(fallback_active, 1'b0)
		tick(1);
		mgmt_ext_select <= 1'b0;
		tick(3);
		#1;
		`CHK(fallback_active, 1'b1)
		clr();
		mac.push_run(S_PAD, 16);
		drain();
		en_off();
	endtask

	initial
	begin
		ref_clk = 1'b0;
		reset = 1'b1;
		slow = 1'b0;
		remod_mode = 1'b0;
		mgmt_ext_select = 1'b0;
		mgmt_tx_disable = 1'b0;
		rx_baud_valid = 1'b0;
		rx_i_code = C0;
		rx_q_code = C0;
		rx_basic_psil = 1'b0;
		rx_modulation = 1'b1;
		loopback_sel = 1'b0;
		n_errors = 0;
		n_checks = 0;
		n_rep = 0;
		scr = 7'h7F;
		sc_remod();
		sc_delim();
		sc_station();
		sc_type();
		complete_run();
	end
endmodule // qdse_encoder_tb_top
